// ### sim/scp_top_checker.sv
// Purpose: Port-level assertions for the clock switch and prescaler block.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes: Bound to every instance of scp_top.
`timescale 1ns/1ps
module scp_top_checker #(
  parameter int SETTLE_CYC = 4
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        crystal_ready,
  input wire logic        crystal_fail,
  input wire logic        lowpower_exit,
  input wire logic [1:0]  system_clock_mux,
  input wire logic        pll_reference_select
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_cfg_write;
    psel && penable && pready && pwrite && (paddr == 8'h04);
  endsequence
  a_ready_after_setup: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_unmapped: assert property (s_setup ##0 (paddr != 8'h04 && paddr != 8'h08) |=> pslverr)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (s_setup ##0 (paddr == 8'h04 || paddr == 8'h08) |=> !pslverr)
    else $error("mapped access refused");
  a_err_zero_data: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("refused access returned data");
  // The select output is a retimed copy of the register, so it lags the write by two edges.
  a_cfg_ref_bit: assert property (s_cfg_write |->
    ##2 pll_reference_select == $past(pwdata[16], 2))
    else $error("pll reference select does not follow write");
  a_mux_no_reserved: assert property (system_clock_mux != 2'h3)
    else $error("reserved source on clock mux");
  a_exit_forces: assert property ($rose(lowpower_exit) |->
    ##[1:8] system_clock_mux == 2'h0)
    else $error("low-power exit did not force internal source");
  a_fail_forces: assert property (crystal_fail && system_clock_mux == 2'h1 |->
    ##[1:8] system_clock_mux == 2'h0)
    else $error("crystal failure did not force internal source");
  a_crystal_mux_ready: assert property ($changed(system_clock_mux) &&
    system_clock_mux == 2'h1 |-> crystal_ready)
    else $error("mux moved to crystal before it was ready");
endmodule : scp_top_checker

bind scp_top scp_top_checker #(.SETTLE_CYC(SETTLE_CYC)) u_chk (.clk(clk), .rst(rst), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .crystal_ready(crystal_ready), .crystal_fail(crystal_fail),
  .lowpower_exit(lowpower_exit), .system_clock_mux(system_clock_mux),
  .pll_reference_select(pll_reference_select));

// ### sim/sysclk_prescaler_and_irq_clear_tb_top.sv
// Purpose: Self-checking bench for the clock switch, prescalers and flag clears.
// Assumes: APB master with one idle cycle between transfers.
// Notes: Tick periods are measured on a clean interval after each divider change.
`timescale 1ns/1ps
module sysclk_prescaler_and_irq_clear_tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd, w, int_exp;
  logic        pready, pslverr, err, pll_ref, t_h, t_p1, t_p2, t_a;
  logic        i8_rdy = 1'b1, xt_rdy = 1'b0, pll_rdy = 1'b0, o14_rdy = 1'b0;
  logic        xt_fail = 1'b0, lp_exit = 1'b0;
  logic [1:0]  mux;
  logic [3:0]  h;
  int          bad_count = 0, num_checks = 0, p, k, b;
  integer      seed = 32'h8df61d8c;

  always #12.5 clk = ~clk;

  scp_top #(.SETTLE_CYC(1)) u_dut (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .internal_8m_ready(i8_rdy), .crystal_ready(xt_rdy), .pll_ready(pll_rdy),
    .osc14_ready(o14_rdy), .crystal_fail(xt_fail), .lowpower_exit(lp_exit),
    .system_clock_mux(mux), .pll_reference_select(pll_ref), .host_bus_tick(t_h),
    .periph_bus_one_tick(t_p1), .periph_bus_two_tick(t_p2), .adc_tick(t_a));

  task final_report;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task xfer(input logic [7:0] a, input logic wr, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= wr; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      chk(32'h0, 32'h1, "bus timeout");
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  // Software must poll the status field; the switch has no fixed latency.
  task wait_status(input logic [1:0] s);
    int n;
    n = 0;
    do begin
      xfer(8'h04, 1'b0, 32'h0);
      n++;
    end while (rd[3:2] !== s && n < 40);
    chk({30'h0, rd[3:2]}, {30'h0, s}, "switch status");
    if (rd[3:2] !== s) final_report();
  endtask : wait_status

  function automatic logic tick_of(int which);
    case (which)
      0: return t_h;
      1: return t_p1;
      2: return t_p2;
      default: return t_a;
    endcase
  endfunction : tick_of

  // The first two intervals may straddle a divider change, so only the third counts.
  task period(input int which, output int pr);
    int n, i;
    for (i = 0; i < 3; i++) begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (tick_of(which) !== 1'b1 && n < 5000);
      if (n >= 5000) begin
        chk(32'h0, 32'h1, "tick timeout");
        final_report();
      end
    end
    pr = n;
  endtask : period

  function automatic int hdiv(logic [3:0] c);
    return c[3] ? ((c[2] ? 4 : 2) << c[2:0]) : 1;
  endfunction : hdiv

  function automatic int pdiv(logic [2:0] c);
    return c[2] ? (2 << c[1:0]) : 1;
  endfunction : pdiv

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    xfer(8'h04, 1'b0, 32'h0);
    chk(rd, 32'h0, "config reset");
    xfer(8'h08, 1'b0, 32'h0);
    chk(rd, 32'h0, "interrupt reset");
    xfer(8'h0c, 1'b0, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped refused");
    for (k = 0; k < 16; k++) begin
      xfer(8'h04, 1'b1, 32'(k) << 4);
      period(0, p);
      chk(p, hdiv(4'(k)), "host period");
    end
    for (k = 0; k < 4; k++) begin
      w = $random(seed);
      h = 4'($unsigned($random(seed)) % 12);
      w = {w[31:8], h, w[3:2], 2'b00};
      xfer(8'h04, 1'b1, w);
      xfer(8'h04, 1'b0, 32'h0);
      chk(rd, w & 32'h0001_fff0, "config readback");
      chk({31'h0, pll_ref}, {31'h0, w[16]}, "pll reference");
      period(1, p);
      chk(p, hdiv(h) * pdiv(w[10:8]), "bus one period");
      period(2, p);
      chk(p, hdiv(h) * pdiv(w[13:11]), "bus two period");
      period(3, p);
      chk(p, hdiv(h) * pdiv(w[13:11]) * 2 * (w[15:14] + 1), "adc period");
    end
    int_exp = 32'h0000_3800;
    xfer(8'h08, 1'b1, int_exp);
    @(posedge clk);
    o14_rdy <= 1'b1; pll_rdy <= 1'b1; xt_rdy <= 1'b1;
    repeat (6) @(posedge clk);
    int_exp = 32'h0000_3838;
    xfer(8'h08, 1'b0, 32'h0);
    chk(rd, int_exp, "flags set");
    xfer(8'h08, 1'b1, 32'h0000_3800);
    xfer(8'h08, 1'b0, 32'h0);
    chk(rd, int_exp, "zero clear");
    for (b = 19; b < 22; b++) begin
      xfer(8'h08, 1'b1, 32'h0000_3800 | (32'h1 << b));
      int_exp = int_exp & ~(32'h1 << (b - 16));
      xfer(8'h08, 1'b0, 32'h0);
      chk(rd, int_exp, "flag clear");
    end
    xfer(8'h04, 1'b1, 32'h1);
    wait_status(2'h1);
    chk({30'h0, mux}, 32'h1, "mux crystal");
    xfer(8'h04, 1'b1, 32'h3);
    xfer(8'h04, 1'b0, 32'h0);
    chk(rd, 32'h5, "reserved select ignored");
    xfer(8'h04, 1'b1, 32'h2);
    wait_status(2'h2);
    chk({30'h0, mux}, 32'h2, "mux pll");
    @(posedge clk);
    lp_exit <= 1'b1;
    repeat (3) @(posedge clk);
    lp_exit <= 1'b0;
    wait_status(2'h0);
    chk(rd, 32'h0, "select forced");
    xfer(8'h04, 1'b1, 32'h1);
    wait_status(2'h1);
    xt_fail <= 1'b1;
    wait_status(2'h0);
    xt_fail <= 1'b0;
    int_exp = 32'h0000_3880;
    xfer(8'h08, 1'b0, 32'h0);
    chk(rd, int_exp, "stuck flag set");
    xfer(8'h08, 1'b1, 32'h0000_3800);
    xfer(8'h08, 1'b0, 32'h0);
    chk(rd, int_exp, "stuck flag held");
    xfer(8'h08, 1'b1, 32'h0080_3800);
    xfer(8'h08, 1'b0, 32'h0);
    chk(rd, 32'h0000_3800, "stuck flag cleared");
    final_report();
  end
endmodule : sysclk_prescaler_and_irq_clear_tb_top

// ### src/scp_div.sv
// Purpose: Tick divider; emits one output tick for every N input ticks.
// Assumes: Divisor is at least one; changes take effect at the next wrap or at once if exceeded.
// Notes: A divisor of one passes every input tick, delayed by one cycle.
`timescale 1ns/1ps
module scp_div #(
  parameter int W = 10
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         in_tick,
  input  wire logic [W-1:0] divisor,
  output logic              out_tick
);

  logic [W-1:0] count_reg;
  logic         wrap;

  // Wrapping also when the count already passed a freshly lowered divisor avoids a long stall.
  assign wrap = (count_reg >= divisor - W'(1));

  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= '0;
      out_tick  <= 1'b0;
    end else begin
      out_tick <= in_tick && wrap;
      if (in_tick) begin
        count_reg <= wrap ? '0 : count_reg + W'(1);
      end
    end
  end

endmodule : scp_div

// ### src/scp_pkg.sv
// Purpose: Shared constants for the system clock prescaler and clock interrupt clear block.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Field positions are the low bit of each field; widths follow the field names.
package scp_pkg;

  localparam logic [7:0]  CFG0_OFFSET      = 8'h04;
  localparam logic [7:0]  INT_OFFSET       = 8'h08;
  localparam logic [31:0] CFG0_RESET       = 32'h0000_0000;
  localparam logic [31:0] INT_RESET        = 32'h0000_0000;

  // Configuration register fields.
  localparam int          PLL_REF_SEL_BIT  = 16;
  localparam int          ADC_DIV_LSB      = 14;
  localparam int          PB2_DIV_LSB      = 11;
  localparam int          PB1_DIV_LSB      = 8;
  localparam int          HB_DIV_LSB       = 4;
  localparam int          SW_STATUS_LSB    = 2;
  localparam int          SW_SELECT_LSB    = 0;

  // Interrupt register fields.
  localparam int          STUCK_CLEAR_BIT  = 23;
  localparam int          OSC14_CLEAR_BIT  = 21;
  localparam int          PLL_CLEAR_BIT    = 20;
  localparam int          XTAL_CLEAR_BIT   = 19;
  localparam int          OSC14_IE_BIT     = 13;
  localparam int          PLL_IE_BIT       = 12;
  localparam int          XTAL_IE_BIT      = 11;
  localparam int          STUCK_FLAG_BIT   = 7;
  localparam int          OSC14_FLAG_BIT   = 5;
  localparam int          PLL_FLAG_BIT     = 4;
  localparam int          XTAL_FLAG_BIT    = 3;

  // System clock source codes, shared by the select and status fields.
  localparam logic [1:0]  SRC_INTERNAL_8M  = 2'h0;
  localparam logic [1:0]  SRC_CRYSTAL      = 2'h1;
  localparam logic [1:0]  SRC_PLL          = 2'h2;
  localparam logic [1:0]  SRC_RESERVED     = 2'h3;

  localparam int          DIV_W            = 10;
  localparam int          SWITCH_SETTLE_CYC = 4;

  typedef enum logic [1:0] {
    SCP_SW_IDLE  = 2'b00,
    SCP_SW_WAIT  = 2'b01,
    SCP_SW_DRIVE = 2'b11
  } scp_sw_state_t;

  // Host bus: 0xxx undivided, 1000..1111 -> 2,4,8,16,64,128,256,512.
  function automatic logic [DIV_W-1:0] host_div(input logic [3:0] code);
    logic [DIV_W-1:0] r;
    r = 10'h001;
    if (code[3]) begin
      unique case (code[2:0])
        3'h0: r = 10'h002;
        3'h1: r = 10'h004;
        3'h2: r = 10'h008;
        3'h3: r = 10'h010;
        3'h4: r = 10'h040;
        3'h5: r = 10'h080;
        3'h6: r = 10'h100;
        3'h7: r = 10'h200;
      endcase
    end
    return r;
  endfunction : host_div

  // Peripheral buses: 0xx undivided, 100..111 -> 2,4,8,16.
  function automatic logic [DIV_W-1:0] periph_div(input logic [2:0] code);
    logic [DIV_W-1:0] r;
    r = 10'h001;
    if (code[2]) begin
      r = 10'h002 << code[1:0];
    end
    return r;
  endfunction : periph_div

  // ADC: 00..11 -> 2,4,6,8.
  function automatic logic [DIV_W-1:0] adc_div(input logic [1:0] code);
    return {7'h00, code, 1'b0} + 10'h002;
  endfunction : adc_div

endpackage : scp_pkg

// ### src/scp_top.sv
// Purpose: System clock source switch, bus prescalers and clock interrupt flag clears.
// Assumes: clk is the system clock; ready and failure inputs arrive from other domains.
// Notes: Derived clocks are produced as one-cycle tick enables for the clock tree.
//
// Notes on behaviour
// - PLL reference is internal 8 MHz over two when bit is 0, crystal when 1.
// - ADC clock is periph bus two clock divided by 2, 4, 6 or 8.
// - Periph bus two clock: 0xx undivided, 100..111 divide by 2, 4, 8, 16.
// - Periph bus one clock: 0xx undivided, 100..111 divide by 2, 4, 8, 16.
// - Host bus clock: 0xxx undivided, 1000..1111 divide by 2..512.
// - Read-only switch status shows the active system clock source.
// - Software selects the system clock source; code 11 is reserved.
// - Leaving deep-sleep or standby forces selection to the internal 8 MHz oscillator.
// - Crystal failure while crystal feeds system clock or PLL forces internal oscillator.
// - Writing 1 to the stuck clear bit clears the clock-stuck flag.
// - Writing 1 to the 14 MHz clear bit clears its stabilization flag.
// - Writing 1 to the PLL clear bit clears the PLL stabilization flag.
// - Writing 1 to the crystal clear bit clears its stabilization flag.
// - The interrupt register resets to all zeros.
// - Stabilization flags set when source becomes stable and its enable is set.
// - Clock-stuck flag sets on detected crystal stuck and holds until cleared.
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module scp_top #(
  parameter int SETTLE_CYC = scp_pkg::SWITCH_SETTLE_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        internal_8m_ready,
  input  wire logic        crystal_ready,
  input  wire logic        pll_ready,
  input  wire logic        osc14_ready,
  input  wire logic        crystal_fail,
  input  wire logic        lowpower_exit,
  output logic      [1:0]  system_clock_mux,
  output logic             pll_reference_select,
  output logic             host_bus_tick,
  output logic             periph_bus_one_tick,
  output logic             periph_bus_two_tick,
  output logic             adc_tick
);

  // Synchroniser bit order.
  localparam int S_I8 = 0;
  localparam int S_XT = 1;
  localparam int S_PL = 2;
  localparam int S_14 = 3;
  localparam int S_FL = 4;
  localparam int S_LP = 5;

  logic [5:0]  sync1_reg;
  logic [5:0]  sync2_reg;
  logic [5:0]  prev_reg;
  logic [5:0]  rise;

  logic        pll_ref_reg;
  logic [1:0]  adc_div_reg;
  logic [2:0]  pb2_div_reg;
  logic [2:0]  pb1_div_reg;
  logic [3:0]  hb_div_reg;
  logic [1:0]  sw_select_reg;
  logic [1:0]  sw_status_reg;

  logic        osc14_ie_reg;
  logic        pll_ie_reg;
  logic        xtal_ie_reg;
  logic        stuck_flag_reg;
  logic        osc14_flag_reg;
  logic        pll_flag_reg;
  logic        xtal_flag_reg;

  scp_pkg::scp_sw_state_t sw_state_reg;
  logic [1:0]  sw_target_reg;
  logic [7:0]  settle_reg;

  logic        setup;
  logic        access;
  logic        wr_cfg;
  logic        wr_int;
  logic        addr_ok;
  logic        force_8m;
  logic        target_ready;
  logic [31:0] cfg_view;
  logic [31:0] int_view;
  logic        hb_tick;
  logic        pb1_tick;
  logic        pb2_tick;
  logic        adc_tk;

  assign setup   = psel && !penable;
  assign access  = psel && penable && pready;
  assign addr_ok = (paddr == scp_pkg::CFG0_OFFSET) ||
                   (paddr == scp_pkg::INT_OFFSET);
  assign wr_cfg  = access && pwrite && (paddr == scp_pkg::CFG0_OFFSET);
  assign wr_int  = access && pwrite && (paddr == scp_pkg::INT_OFFSET);
  assign rise    = sync2_reg & ~prev_reg;

  // Pins cross into the system clock domain through two flops before anything reads them.
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_reg <= 6'h00;
      sync2_reg <= 6'h00;
      prev_reg  <= 6'h00;
    end else begin
      sync1_reg <= {lowpower_exit, crystal_fail, osc14_ready,
                    pll_ready, crystal_ready, internal_8m_ready};
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // A failure forces the fall-back only while the crystal is the status or pending target, or the PLL reference.
  assign force_8m = rise[S_LP] ||
                    (sync2_reg[S_FL] && ((sw_status_reg == scp_pkg::SRC_CRYSTAL) ||
                                         (sw_target_reg == scp_pkg::SRC_CRYSTAL &&
                                          sw_state_reg != scp_pkg::SCP_SW_IDLE) ||
                                         pll_ref_reg));

  always_comb begin
    cfg_view = 32'h0000_0000;
    cfg_view[scp_pkg::PLL_REF_SEL_BIT]                 = pll_ref_reg;
    cfg_view[scp_pkg::ADC_DIV_LSB +: 2]                = adc_div_reg;
    cfg_view[scp_pkg::PB2_DIV_LSB +: 3]                = pb2_div_reg;
    cfg_view[scp_pkg::PB1_DIV_LSB +: 3]                = pb1_div_reg;
    cfg_view[scp_pkg::HB_DIV_LSB +: 4]                 = hb_div_reg;
    cfg_view[scp_pkg::SW_STATUS_LSB +: 2]              = sw_status_reg;
    cfg_view[scp_pkg::SW_SELECT_LSB +: 2]              = sw_select_reg;
  end

  // Clear bits are write-only and read as zero.
  always_comb begin
    int_view = 32'h0000_0000;
    int_view[scp_pkg::OSC14_IE_BIT]   = osc14_ie_reg;
    int_view[scp_pkg::PLL_IE_BIT]     = pll_ie_reg;
    int_view[scp_pkg::XTAL_IE_BIT]    = xtal_ie_reg;
    int_view[scp_pkg::STUCK_FLAG_BIT] = stuck_flag_reg;
    int_view[scp_pkg::OSC14_FLAG_BIT] = osc14_flag_reg;
    int_view[scp_pkg::PLL_FLAG_BIT]   = pll_flag_reg;
    int_view[scp_pkg::XTAL_FLAG_BIT]  = xtal_flag_reg;
  end

  // Bus slave: ready in the cycle after setup, so every access takes exactly two cycles.
  always_ff @(posedge clk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready <= setup;
      if (setup) begin
        pslverr <= !addr_ok;
        if (!pwrite && paddr == scp_pkg::CFG0_OFFSET) begin
          prdata <= cfg_view;
        end else if (!pwrite && paddr == scp_pkg::INT_OFFSET) begin
          prdata <= int_view;
        end else begin
          prdata <= 32'h0000_0000;
        end
      end else if (access) begin
        pslverr <= 1'b0;
      end
    end
  end

  // Prescaler fields and PLL reference select.
  always_ff @(posedge clk) begin
    if (rst) begin
      pll_ref_reg <= scp_pkg::CFG0_RESET[scp_pkg::PLL_REF_SEL_BIT];
      adc_div_reg <= scp_pkg::CFG0_RESET[scp_pkg::ADC_DIV_LSB +: 2];
      pb2_div_reg <= scp_pkg::CFG0_RESET[scp_pkg::PB2_DIV_LSB +: 3];
      pb1_div_reg <= scp_pkg::CFG0_RESET[scp_pkg::PB1_DIV_LSB +: 3];
      hb_div_reg  <= scp_pkg::CFG0_RESET[scp_pkg::HB_DIV_LSB +: 4];
    end else if (wr_cfg) begin
      pll_ref_reg <= pwdata[scp_pkg::PLL_REF_SEL_BIT];
      adc_div_reg <= pwdata[scp_pkg::ADC_DIV_LSB +: 2];
      pb2_div_reg <= pwdata[scp_pkg::PB2_DIV_LSB +: 3];
      pb1_div_reg <= pwdata[scp_pkg::PB1_DIV_LSB +: 3];
      hb_div_reg  <= pwdata[scp_pkg::HB_DIV_LSB +: 4];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pll_reference_select <= 1'b0;
    end else begin
      pll_reference_select <= pll_ref_reg;
    end
  end

  // Source select; a forced fall-back overrides a write in the same cycle.
  always_ff @(posedge clk) begin
    if (rst) begin
      sw_select_reg <= scp_pkg::CFG0_RESET[scp_pkg::SW_SELECT_LSB +: 2];
    end else if (force_8m) begin
      sw_select_reg <= scp_pkg::SRC_INTERNAL_8M;
    end else if (wr_cfg &&
                 pwdata[scp_pkg::SW_SELECT_LSB +: 2] != scp_pkg::SRC_RESERVED) begin
      sw_select_reg <= pwdata[scp_pkg::SW_SELECT_LSB +: 2];
    end
  end

  always_comb begin
    unique case (sw_target_reg)
      scp_pkg::SRC_CRYSTAL: target_ready = sync2_reg[S_XT];
      scp_pkg::SRC_PLL:     target_ready = sync2_reg[S_PL];
      default:              target_ready = sync2_reg[S_I8];
    endcase
  end

  // Switch sequencer: the old source keeps driving until the new one is ready; status follows once the settle count runs out.
  always_ff @(posedge clk) begin
    if (rst) begin
      sw_state_reg     <= scp_pkg::SCP_SW_IDLE;
      sw_target_reg    <= scp_pkg::SRC_INTERNAL_8M;
      sw_status_reg    <= scp_pkg::SRC_INTERNAL_8M;
      system_clock_mux <= scp_pkg::SRC_INTERNAL_8M;
      settle_reg       <= 8'h00;
    end else if (force_8m) begin
      // Emergency path: the failed crystal cannot be waited on.
      sw_state_reg     <= scp_pkg::SCP_SW_IDLE;
      sw_target_reg    <= scp_pkg::SRC_INTERNAL_8M;
      sw_status_reg    <= scp_pkg::SRC_INTERNAL_8M;
      system_clock_mux <= scp_pkg::SRC_INTERNAL_8M;
      settle_reg       <= 8'h00;
    end else begin
      unique case (sw_state_reg)
        scp_pkg::SCP_SW_IDLE: begin
          if (sw_select_reg != sw_status_reg) begin
            sw_target_reg <= sw_select_reg;
            sw_state_reg  <= scp_pkg::SCP_SW_WAIT;
          end
        end
        scp_pkg::SCP_SW_WAIT: begin
          if (sw_select_reg != sw_target_reg) begin
            sw_state_reg <= scp_pkg::SCP_SW_IDLE;
          end else if (target_ready) begin
            system_clock_mux <= sw_target_reg;
            settle_reg       <= 8'(SETTLE_CYC);
            sw_state_reg     <= scp_pkg::SCP_SW_DRIVE;
          end
        end
        scp_pkg::SCP_SW_DRIVE: begin
          if (settle_reg <= 8'h01) begin
            sw_status_reg <= sw_target_reg;
            sw_state_reg  <= scp_pkg::SCP_SW_IDLE;
          end else begin
            settle_reg <= settle_reg - 8'h01;
          end
        end
        default: sw_state_reg <= scp_pkg::SCP_SW_IDLE;
      endcase
    end
  end

  // Interrupt enables; reserved bits are not stored.
  always_ff @(posedge clk) begin
    if (rst) begin
      osc14_ie_reg <= scp_pkg::INT_RESET[scp_pkg::OSC14_IE_BIT];
      pll_ie_reg   <= scp_pkg::INT_RESET[scp_pkg::PLL_IE_BIT];
      xtal_ie_reg  <= scp_pkg::INT_RESET[scp_pkg::XTAL_IE_BIT];
    end else if (wr_int) begin
      osc14_ie_reg <= pwdata[scp_pkg::OSC14_IE_BIT];
      pll_ie_reg   <= pwdata[scp_pkg::PLL_IE_BIT];
      xtal_ie_reg  <= pwdata[scp_pkg::XTAL_IE_BIT];
    end
  end

  // Flags: a hardware set in the same cycle as a software clear wins.
  always_ff @(posedge clk) begin
    if (rst) begin
      stuck_flag_reg <= scp_pkg::INT_RESET[scp_pkg::STUCK_FLAG_BIT];
      osc14_flag_reg <= scp_pkg::INT_RESET[scp_pkg::OSC14_FLAG_BIT];
      pll_flag_reg   <= scp_pkg::INT_RESET[scp_pkg::PLL_FLAG_BIT];
      xtal_flag_reg  <= scp_pkg::INT_RESET[scp_pkg::XTAL_FLAG_BIT];
    end else begin
      if (rise[S_FL]) begin
        stuck_flag_reg <= 1'b1;
      end else if (wr_int && pwdata[scp_pkg::STUCK_CLEAR_BIT]) begin
        stuck_flag_reg <= 1'b0;
      end
      if (rise[S_14] && osc14_ie_reg) begin
        osc14_flag_reg <= 1'b1;
      end else if (wr_int && pwdata[scp_pkg::OSC14_CLEAR_BIT]) begin
        osc14_flag_reg <= 1'b0;
      end
      if (rise[S_PL] && pll_ie_reg) begin
        pll_flag_reg <= 1'b1;
      end else if (wr_int && pwdata[scp_pkg::PLL_CLEAR_BIT]) begin
        pll_flag_reg <= 1'b0;
      end
      if (rise[S_XT] && xtal_ie_reg) begin
        xtal_flag_reg <= 1'b1;
      end else if (wr_int && pwdata[scp_pkg::XTAL_CLEAR_BIT]) begin
        xtal_flag_reg <= 1'b0;
      end
    end
  end

  // Prescaler chain: system clock -> host bus -> both peripheral buses; peripheral bus two -> ADC.
  scp_div #(.W(scp_pkg::DIV_W)) u_host_div (
    .clk      (clk),
    .rst      (rst),
    .in_tick  (1'b1),
    .divisor  (scp_pkg::host_div(hb_div_reg)),
    .out_tick (hb_tick)
  );

  scp_div #(.W(scp_pkg::DIV_W)) u_pb1_div (
    .clk      (clk),
    .rst      (rst),
    .in_tick  (hb_tick),
    .divisor  (scp_pkg::periph_div(pb1_div_reg)),
    .out_tick (pb1_tick)
  );

  scp_div #(.W(scp_pkg::DIV_W)) u_pb2_div (
    .clk      (clk),
    .rst      (rst),
    .in_tick  (hb_tick),
    .divisor  (scp_pkg::periph_div(pb2_div_reg)),
    .out_tick (pb2_tick)
  );

  scp_div #(.W(scp_pkg::DIV_W)) u_adc_div (
    .clk      (clk),
    .rst      (rst),
    .in_tick  (pb2_tick),
    .divisor  (scp_pkg::adc_div(adc_div_reg)),
    .out_tick (adc_tk)
  );

  // Retimed so every tick output leaves from a flop of this module.
  always_ff @(posedge clk) begin
    if (rst) begin
      host_bus_tick       <= 1'b0;
      periph_bus_one_tick <= 1'b0;
      periph_bus_two_tick <= 1'b0;
      adc_tick            <= 1'b0;
    end else begin
      host_bus_tick       <= hb_tick;
      periph_bus_one_tick <= pb1_tick;
      periph_bus_two_tick <= pb2_tick;
      adc_tick            <= adc_tk;
    end
  end

endmodule : scp_top
